//--- hw/dim_pkg.sv
// package for the discrete input register map block
package dim_pkg;
  localparam int          CHANNELS      = 16;
  localparam int          GROUP_WIDTH   = 4;
  localparam int          GROUPS        = 4;
  localparam int          WORD_WIDTH    = 16;
  // register offsets
  localparam logic [15:0] ADDR_GROUP0   = 16'h0000;
  localparam logic [15:0] ADDR_GROUP1   = 16'h0001;
  localparam logic [15:0] ADDR_GROUP2   = 16'h0002;
  localparam logic [15:0] ADDR_GROUP3   = 16'h0003;
  localparam logic [15:0] ADDR_TICK     = 16'h0004;
  localparam logic [15:0] ADDR_WDOG     = 16'h0004;
  // function codes
  localparam logic [7:0]  FC_READ_HOLD  = 8'h03;
  localparam logic [7:0]  FC_READ_INPUT = 8'h04;
  localparam logic [7:0]  FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0]  FC_WRITE_MANY = 8'h10;
  // exception codes
  localparam logic [7:0]  EXC_NONE      = 8'h00;
  localparam logic [7:0]  EXC_FUNCTION  = 8'h01;
  localparam logic [7:0]  EXC_ADDRESS   = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  // reset values
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [15:0] UNUSED_MASK   = 16'h000F;
  // tick counter step per transfer answered without exception
  localparam logic [15:0] TICK_STEP     = 16'h0001;

  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] data;
  } dim_req_type;

  typedef struct packed {
    logic [7:0]  func;
    logic [7:0]  exc;
    logic [15:0] data;
  } dim_rsp_type;
endpackage

//--- hw/dim_top.sv
// discrete input register map: input state words, tick counter, holding words
// How it works
// - each discrete value is one bit of a sixteen-bit word
// - watchdog time held as unsigned sixteen-bit value, full range
// - channel state sits at bit matching its channel number in group
// - output bit one closes switch, zero opens it
// - input on or high reads one, off or low reads zero
// - invert setting flips reported input states when enabled
// - upper bits fifteen to four of input words read zero
// - input bit set when channel on, cleared when off
// - tick counter increments by one per transfer answered without exception
// - tick counter wraps from 65535 back to zero
// - holding contents volatile, cleared by reset
// - no configuration registers on the network map
// - lowest channel of group in least significant bit
// - unsupported function gives exception 01, bad write value 03
`timescale 1ns/1ps
module dim_top (
  input  wire logic                CLK_I,
  input  wire logic                RESETN_I,
  input  wire logic                CE_I,
  input  wire logic [15:0]         FIELD_IN_I,
  input  wire logic                INVERT_INPUTS_I,
  input  wire logic                WDOG_LOAD_I,
  input  wire logic [15:0]         WDOG_TIME_I,
  input  wire logic                REQ_VALID_I,
  input  wire dim_pkg::dim_req_type REQ_I,
  output logic                     RSP_VALID_O,
  output dim_pkg::dim_rsp_type     RSP_O,
  output logic [15:0]              OUT_SWITCH_O,
  output logic [15:0]              WDOG_TIME_O
);
  logic        rst_meta_reg;
  logic        rst_sync_reg;
  logic [15:0] pin_meta_reg;
  logic [15:0] pin_sync_reg;
  logic        inv_meta_reg;
  logic        inv_sync_reg;
  logic [15:0] state_reg [dim_pkg::GROUPS];
  logic [15:0] state_next [dim_pkg::GROUPS];
  logic [15:0] hold_reg [dim_pkg::GROUPS];
  logic [15:0] hold_next [dim_pkg::GROUPS];
  logic [15:0] tick_reg;
  logic [15:0] tick_next;
  logic [15:0] wdog_reg;
  logic [15:0] wdog_next;
  logic        rsp_valid_reg;
  logic        rsp_valid_next;
  dim_pkg::dim_rsp_type rsp_reg;
  dim_pkg::dim_rsp_type rsp_next;
  logic        req_read_in;
  logic        req_read_hold;
  logic        req_write;
  logic        req_bad_func;
  logic [7:0]  req_exc;
  logic [15:0] read_data;
  logic [15:0] out_reg;
  logic [15:0] out_next;

  // address falls inside the four group words
  function automatic logic in_groups(input logic [15:0] addr);
    in_groups = (addr <= dim_pkg::ADDR_GROUP3);
  endfunction

  // address readable through the input read
  function automatic logic in_input_map(input logic [15:0] addr);
    in_input_map = in_groups(addr) || (addr == dim_pkg::ADDR_TICK);
  endfunction

  // address readable through the holding read
  function automatic logic in_hold_map(input logic [15:0] addr);
    in_hold_map = in_groups(addr) || (addr == dim_pkg::ADDR_WDOG);
  endfunction

  // written value uses only the four channel bits
  function automatic logic value_ok(input logic [15:0] data);
    value_ok = ((data & ~dim_pkg::UNUSED_MASK) == dim_pkg::RESET_WORD);
  endfunction

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      pin_meta_reg <= dim_pkg::RESET_WORD;
      pin_sync_reg <= dim_pkg::RESET_WORD;
      inv_meta_reg <= 1'b0;
      inv_sync_reg <= 1'b0;
    end
    else if (CE_I)
    begin
      pin_meta_reg <= FIELD_IN_I;
      pin_sync_reg <= pin_meta_reg;
      inv_meta_reg <= INVERT_INPUTS_I;
      inv_sync_reg <= inv_meta_reg;
    end
  end

  // input state words, one per group of four channels
  genvar g;
  generate
    for (g = 0; g < dim_pkg::GROUPS; g++)
    begin : gen_group
      always_comb
      begin
        state_next[g] = dim_pkg::RESET_WORD;
        state_next[g][dim_pkg::GROUP_WIDTH-1:0] =
          pin_sync_reg[g*dim_pkg::GROUP_WIDTH +: dim_pkg::GROUP_WIDTH]
          ^ {dim_pkg::GROUP_WIDTH{inv_sync_reg}};
      end
      always_ff @(posedge CLK_I or negedge rst_sync_reg)
      begin
        if (!rst_sync_reg)
          state_reg[g] <= dim_pkg::RESET_WORD;
        else if (CE_I)
          state_reg[g] <= state_next[g];
      end
    end
  endgenerate

  // request class decode
  always_comb
  begin
    req_read_in   = 1'b0;
    req_read_hold = 1'b0;
    req_write     = 1'b0;
    req_bad_func  = 1'b0;
    if (REQ_VALID_I)
    begin
      unique case (REQ_I.func)
        dim_pkg::FC_READ_INPUT:
          req_read_in = 1'b1;
        dim_pkg::FC_READ_HOLD:
          req_read_hold = 1'b1;
        dim_pkg::FC_WRITE_ONE, dim_pkg::FC_WRITE_MANY:
          req_write = 1'b1;
        default:
          req_bad_func = 1'b1;
      endcase
    end
  end

  // exception code of the current request
  always_comb
  begin
    req_exc = dim_pkg::EXC_NONE;
    if (req_bad_func)
      req_exc = dim_pkg::EXC_FUNCTION;
    else if (req_read_in && !in_input_map(REQ_I.addr))
      req_exc = dim_pkg::EXC_ADDRESS;
    else if (req_read_hold && !in_hold_map(REQ_I.addr))
      req_exc = dim_pkg::EXC_ADDRESS;
    else if (req_write && !in_groups(REQ_I.addr))
      req_exc = dim_pkg::EXC_ADDRESS;
    else if (req_write && !value_ok(REQ_I.data))
      req_exc = dim_pkg::EXC_VALUE;
  end

  // answer data selection
  always_comb
  begin
    read_data = dim_pkg::RESET_WORD;
    if (req_write)
      read_data = REQ_I.data;
    else if (req_read_in && in_groups(REQ_I.addr))
      read_data = state_reg[REQ_I.addr[1:0]];
    else if (req_read_in && REQ_I.addr == dim_pkg::ADDR_TICK)
      read_data = tick_reg;
    else if (req_read_hold && in_groups(REQ_I.addr))
      read_data = hold_reg[REQ_I.addr[1:0]];
    else if (req_read_hold && REQ_I.addr == dim_pkg::ADDR_WDOG)
      read_data = wdog_reg;
  end

  // holding words, written only by accepted writes
  always_comb
  begin
    hold_next = hold_reg;
    if (req_write && req_exc == dim_pkg::EXC_NONE)
      hold_next[REQ_I.addr[1:0]] = REQ_I.data;
  end

  always_ff @(posedge CLK_I or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      hold_reg <= '{default: dim_pkg::RESET_WORD};
    else if (CE_I)
      hold_reg <= hold_next;
  end

  // one bit per switch, one closes it
  always_comb
  begin
    out_next = dim_pkg::RESET_WORD;
    for (int i = 0; i < dim_pkg::GROUPS; i++)
      out_next[i*dim_pkg::GROUP_WIDTH +: dim_pkg::GROUP_WIDTH] =
        hold_next[i][dim_pkg::GROUP_WIDTH-1:0];
  end

  always_ff @(posedge CLK_I or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      out_reg <= dim_pkg::RESET_WORD;
    else if (CE_I)
      out_reg <= out_next;
  end

  // count each transfer answered without exception, wraps to zero
  always_comb
  begin
    tick_next = tick_reg;
    if (REQ_VALID_I && req_exc == dim_pkg::EXC_NONE)
      tick_next = 16'(tick_reg + dim_pkg::TICK_STEP);
  end

  always_ff @(posedge CLK_I or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      tick_reg <= dim_pkg::RESET_WORD;
    else if (CE_I)
      tick_reg <= tick_next;
  end

  always_comb
  begin
    wdog_next = wdog_reg;
    if (WDOG_LOAD_I)
      wdog_next = WDOG_TIME_I;
  end

  always_ff @(posedge CLK_I or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      wdog_reg <= dim_pkg::RESET_WORD;
    else if (CE_I)
      wdog_reg <= wdog_next;
  end

  // answer, one cycle after the request
  always_comb
  begin
    rsp_valid_next = REQ_VALID_I;
    rsp_next       = rsp_reg;
    if (REQ_VALID_I)
    begin
      rsp_next.func = REQ_I.func;
      rsp_next.exc  = req_exc;
      rsp_next.data = read_data;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_reg       <= '0;
    end
    else if (CE_I)
    begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_reg       <= rsp_next;
    end
  end

  assign OUT_SWITCH_O = out_reg;
  assign RSP_VALID_O  = rsp_valid_reg;
  assign RSP_O        = rsp_reg;
  assign WDOG_TIME_O  = wdog_reg;
endmodule

//--- dv/dim_chk.sv
// assertions on the register map ports
`timescale 1ns/1ps
module dim_chk (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic WDOG_LOAD_I,
  input wire logic [15:0] WDOG_TIME_I,
  input wire logic REQ_VALID_I,
  input wire dim_pkg::dim_req_type REQ_I,
  input wire logic RSP_VALID_O,
  input wire dim_pkg::dim_rsp_type RSP_O,
  input wire logic [15:0] OUT_SWITCH_O,
  input wire logic [15:0] WDOG_TIME_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire go = CE_I && REQ_VALID_I;
  wire [7:0] fn = go ? REQ_I.func : 8'h00;
  wire lo = REQ_I.addr < 16'h0004;
  wire ri = fn == 8'h04 && lo;
  wire tk = fn == 8'h04 && REQ_I.addr == 16'h0004;
  wire bf = go && !(fn inside {8'h03, 8'h04, 8'h06, 8'h10});
  wire bv = fn == 8'h06 && lo && |REQ_I.data[15:4];
  wire ws = fn == 8'h06 && REQ_I.addr == 16'h0000 && !bv;
  rsp_late_a: assert property (go |=> RSP_VALID_O) else $error("no answer");
  rsp_stray_a: assert property (!go |=> !RSP_VALID_O) else $error("stray");
  bad_func_a: assert property (bf |=> RSP_O.exc == 8'h01) else $error("code");
  bad_value_a: assert property (bv |=> RSP_O.exc == 8'h03) else $error("value");
  upper_zero_a: assert property (ri |=> RSP_O.data[15:4] == 12'h000) else $error("upper");
  read_ok_a: assert property (tk || ri |=> RSP_O.exc == 8'h00) else $error("refused");
  switch_set_a:
    assert property (ws |=> OUT_SWITCH_O[3:0] == $past(REQ_I.data[3:0])) else $error("switch");
  wdog_load_a:
    assert property (CE_I && WDOG_LOAD_I |=> WDOG_TIME_O == $past(WDOG_TIME_I)) else $error("wdog");
  tick_step_a:
    assert property (tk ##1 tk |=> RSP_O.data == $past(RSP_O.data) + 16'h0001) else $error("tick");
endmodule
bind dim_top dim_chk dim_chk_i (.*);

//--- dv/dim_master.sv
// network master model issuing register requests
`timescale 1ns/1ps
module dim_master (
  input  wire logic                 clk_i,
  input  wire logic                 rsp_valid_i,
  input  wire dim_pkg::dim_rsp_type rsp_i,
  output logic                      req_valid_o,
  output dim_pkg::dim_req_type      req_o
);
  initial {req_valid_o, req_o} = '0;
  // random start gap, n requests back to back, released bus inverted
  task automatic xfer(input logic [39:0] q, input int n, output logic ok,
    output dim_pkg::dim_rsp_type r);
    repeat ($urandom_range(2, 1)) @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_o <= q;
    repeat (n) @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_o <= ~q;
    #1 ok = rsp_valid_i === 1'b1;
    r = rsp_i;
  endtask
endmodule

//--- dv/discrete_input_register_map_bench.sv
// bench of the discrete input register map
`timescale 1ns/1ps
`define CHK(a, b) chk(16'(a), 16'(b))
module discrete_input_register_map_bench;
  logic c, rn, iv, ld, rv, vo, ok, ce;
  logic [15:0] fin, wt, sw, wo, es;
  dim_pkg::dim_req_type rq;
  dim_pkg::dim_rsp_type rs, r;
  int error_cnt, n_checks, t;
  dim_top dim_top_i (.CLK_I(c), .RESETN_I(rn), .CE_I(ce), .FIELD_IN_I(fin),
    .INVERT_INPUTS_I(iv), .WDOG_LOAD_I(ld), .WDOG_TIME_I(wt), .REQ_VALID_I(rv),
    .REQ_I(rq), .RSP_VALID_O(vo), .RSP_O(rs), .OUT_SWITCH_O(sw), .WDOG_TIME_O(wo));
  dim_master dim_master_i (.clk_i(c), .rsp_valid_i(vo), .rsp_i(rs), .req_valid_o(rv),
    .req_o(rq));
  initial
  begin
    c = 1'b0;
    forever #2 c = ~c;
  end
  task automatic chk(input logic [15:0] a, e);
    n_checks++;
    error_cnt += int'(a !== e);
    if (a !== e)
      $display("[ERR] %0t got %h want %h", $time, a, e);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, d, input int n = 1);
    dim_master_i.xfer({f, a, d}, n, ok, r);
    `CHK(ok, 1'b1);
    if (!ok)
      tally_and_finish();
  endtask
  function automatic logic [15:0] grp(int g);
    return ((iv ? ~fin : fin) >> (4 * g)) & 16'h000F;
  endfunction
  initial
  begin
    {rn, iv, ld, fin, wt, es} = '0;
    ce = 1'b1;
    t = $urandom(70);
    repeat (2) @(posedge c);
    @(posedge c) rn <= 1'b1;
    repeat (3) @(posedge c);
    repeat (20)
    begin
      @(posedge c) {iv, fin} <= 17'($urandom);
      repeat (4) @(posedge c);
      for (int g = 0; g < 4; g++)
      begin
        xfer(8'h04, 16'(g), 16'h0000);
        `CHK(r.data, grp(g));
      end
    end
    xfer(8'h04, 16'h0004, 16'h0000);
    xfer(8'h04, 16'h0004, 16'h0000, 65534 - int'(r.data));
    `CHK(r.data, 16'hFFFE);
    xfer(8'h04, 16'h0004, 16'h0000, 2);
    `CHK(r.data, 16'h0000);
    for (int g = 0; g < 4; g++)
    begin
      xfer(8'(g * 7 + 1), 16'h0000, 16'h0000);
      `CHK(r.exc, 8'h01);
      t = $urandom_range(15);
      es[4 * g +: 4] = 4'(t);
      xfer(g[0] ? 8'h10 : 8'h06, 16'(g), 16'(t));
      `CHK(sw, es);
    end
    xfer(8'h06, 16'h0000, 16'h0010);
    `CHK(r.exc, 8'h03);
    `CHK(sw, es);
    xfer(8'h04, 16'h0005, 16'h0000);
    `CHK(r.exc, 8'h02);
    `CHK(r.func, 8'h04);
    @(posedge c) {ce, ld, wt} <= 18'h1_1234;
    @(posedge c) {ce, ld} <= 2'b10;
    xfer(8'h03, 16'h0004, 16'h0000);
    `CHK(r.data, 16'h0000);
    `CHK(wo, 16'h0000);
    @(posedge c) {ld, wt} <= 17'h1_FFFF;
    @(posedge c) ld <= 1'b0;
    xfer(8'h03, 16'h0004, 16'h0000);
    `CHK(r.data, 16'hFFFF);
    `CHK(wo, 16'hFFFF);
    tally_and_finish();
  end
endmodule
